// *** rtl/eiv_pkg.sv ***
// Package: register map, field positions and reset values of the vector/edge control block
package eiv_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int unsigned EIV_NUM_EXT   = 5;
   localparam int unsigned EIV_ADDR_W    = 4;
   localparam int unsigned EIV_DATA_W    = 32;
   localparam int unsigned EIV_REG_W     = 16;
   localparam int unsigned EIV_SYNC_LEN  = 2;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [EIV_ADDR_W-1:0] EIV_OFF_CTRL_TWO = 4'h0;
   localparam logic [EIV_ADDR_W-1:0] EIV_OFF_FLAGS    = 4'h4;
   localparam logic [EIV_ADDR_W-1:0] EIV_OFF_ENABLES  = 4'h8;

   // ****************************************
   // Field positions in interrupt_control_two
   // ****************************************
   localparam int unsigned EIV_BIT_ALT_TABLE  = 15;
   localparam int unsigned EIV_BIT_DIS_STAT   = 14;
   localparam int unsigned EIV_BIT_POL_LSB    = 0;
   localparam int unsigned EIV_BYTE_POL       = 0;
   localparam int unsigned EIV_BYTE_ALT       = 1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic                   EIV_RST_ALT_TABLE = 1'b0;
   localparam logic [EIV_NUM_EXT-1:0] EIV_RST_POLARITY  = 5'h00;
   localparam logic [EIV_NUM_EXT-1:0] EIV_RST_FLAGS     = 5'h00;
   localparam logic [EIV_NUM_EXT-1:0] EIV_RST_ENABLES   = 5'h00;

   // ****************************************
   // Bus answers
   // ****************************************
   localparam logic [1:0] EIV_RESP_OKAY   = 2'h0;
   localparam logic [1:0] EIV_RESP_DECERR = 2'h3;

   // Register selected by an address
   typedef enum logic [1:0] {
      EIV_SEL_NONE  = 2'h0,
      EIV_SEL_CTRL  = 2'h1,
      EIV_SEL_FLAGS = 2'h3,
      EIV_SEL_EN    = 2'h2
   } eiv_sel_e;
endpackage

// *** rtl/eiv_edge_det.sv ***
// Synchroniser and per-input edge detector for the external interrupt inputs
`timescale 1ns/1ps
module eiv_edge_det #(
   parameter int unsigned N = 5
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic [N-1:0] i_pins,
   input  wire logic [N-1:0] i_falling_sel,
   output logic      [N-1:0] o_edge_pulse
);
   import eiv_pkg::*;

   logic [N-1:0] sync1_ff;
   logic [N-1:0] sync2_ff;
   logic [N-1:0] prev_ff;

   // Two-stage synchroniser, first stage read only by the second
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end else begin
         sync1_ff <= i_pins;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // Compare samples; polarity change alone never fakes an edge
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_edge_pulse <= '0;
      end else begin
         o_edge_pulse <= (i_falling_sel & ~sync2_ff & prev_ff)
                       | (~i_falling_sel & sync2_ff & ~prev_ff);
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_rise_detect: assert property (sync2_ff[0] && !prev_ff[0] && !i_falling_sel[0]
      |=> o_edge_pulse[0]) else $error("rising edge on input 0 missed");
   a_fall_detect: assert property (!sync2_ff[0] && prev_ff[0] && i_falling_sel[0]
      |=> o_edge_pulse[0]) else $error("falling edge on input 0 missed");
   a_pulse_single: assert property (o_edge_pulse[0] |=> !o_edge_pulse[0])
      else $error("edge pulse longer than one cycle");
endmodule // eiv_edge_det

// *** rtl/eiv_ctrl.sv ***
// Top: second interrupt control register, external edge flags and AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module eiv_ctrl #(
   parameter int unsigned NUM_EXT = eiv_pkg::EIV_NUM_EXT
) (
   input  wire logic                          i_clock,
   input  wire logic                          i_rst,
   // AXI4-Lite write address
   input  wire logic                          i_awvalid,
   output logic                               o_awready,
   input  wire logic [eiv_pkg::EIV_ADDR_W-1:0] i_awaddr,
   // AXI4-Lite write data
   input  wire logic                          i_wvalid,
   output logic                               o_wready,
   input  wire logic [eiv_pkg::EIV_DATA_W-1:0] i_wdata,
   input  wire logic [3:0]                    i_wstrb,
   // AXI4-Lite write response
   output logic                               o_bvalid,
   input  wire logic                          i_bready,
   output logic [1:0]                         o_bresp,
   // AXI4-Lite read address
   input  wire logic                          i_arvalid,
   output logic                               o_arready,
   input  wire logic [eiv_pkg::EIV_ADDR_W-1:0] i_araddr,
   // AXI4-Lite read data
   output logic                               o_rvalid,
   input  wire logic                          i_rready,
   output logic [eiv_pkg::EIV_DATA_W-1:0]     o_rdata,
   output logic [1:0]                         o_rresp,
   // Device side
   input  wire logic [NUM_EXT-1:0]            i_ext_irq_pins,
   input  wire logic                          i_irq_disable_instr_active,
   output logic                               o_alt_vector_table_enable,
   output logic [NUM_EXT-1:0]                 o_ext_irq_flags,
   output logic [NUM_EXT-1:0]                 o_ext_irq_req
);
   import eiv_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic                  alt_table_ff;
   logic [NUM_EXT-1:0]    polarity_ff;
   logic [NUM_EXT-1:0]    flags_ff;
   logic [NUM_EXT-1:0]    enables_ff;
   logic [NUM_EXT-1:0]    edge_pulse;
   logic                  aw_held_ff;
   logic [EIV_ADDR_W-1:0] aw_addr_ff;
   logic                  w_held_ff;
   logic [EIV_DATA_W-1:0] w_data_ff;
   logic [3:0]            w_strb_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  rvalid_ff;
   logic [EIV_DATA_W-1:0] rdata_ff;
   logic [1:0]            rresp_ff;
   logic                  wr_fire;
   eiv_sel_e              wr_sel;
   eiv_sel_e              rd_sel;
   logic [NUM_EXT-1:0]    flag_clear;

   // Address decode, shared by both bus directions
   function automatic eiv_sel_e decode(input logic [EIV_ADDR_W-1:0] addr);
      unique case (addr)
         EIV_OFF_CTRL_TWO: decode = EIV_SEL_CTRL;
         EIV_OFF_FLAGS:    decode = EIV_SEL_FLAGS;
         EIV_OFF_ENABLES:  decode = EIV_SEL_EN;
         default:          decode = EIV_SEL_NONE;
      endcase
   endfunction

   // Pad a source-wide vector to a bus word
   function automatic logic [EIV_DATA_W-1:0] widen(input logic [NUM_EXT-1:0] v);
      widen = '0;
      widen[NUM_EXT-1:0] = v;
   endfunction

   // ****************************************
   // Edge detection
   // ****************************************
   eiv_edge_det #(
      .N (NUM_EXT)
   ) u_edge (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .i_pins        (i_ext_irq_pins),
      .i_falling_sel (polarity_ff),
      .o_edge_pulse  (edge_pulse)
   );

   // ****************************************
   // AXI4-Lite write path
   // ****************************************
   // Address and data captured independently, in either order
   assign o_awready = !aw_held_ff && !bvalid_ff;
   assign o_wready  = !w_held_ff && !bvalid_ff;
   assign wr_fire   = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_sel    = decode(aw_addr_ff);
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;

   // Write channel holding stages
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_held_ff  <= 1'b0;
         w_data_ff  <= '0;
         w_strb_ff  <= '0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= i_awaddr;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= i_wdata;
            w_strb_ff <= i_wstrb;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // Response one cycle after both halves are in
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= EIV_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_sel == EIV_SEL_NONE) ? EIV_RESP_DECERR : EIV_RESP_OKAY;
      end else if (i_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ****************************************
   // Control register fields
   // ****************************************
   // Status bit 14 has no storage, so no write can reach it
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         alt_table_ff <= EIV_RST_ALT_TABLE;
         polarity_ff  <= EIV_RST_POLARITY;
      end else if (wr_fire && wr_sel == EIV_SEL_CTRL) begin
         if (w_strb_ff[EIV_BYTE_ALT]) begin
            alt_table_ff <= w_data_ff[EIV_BIT_ALT_TABLE];
         end
         if (w_strb_ff[EIV_BYTE_POL]) begin
            polarity_ff <= w_data_ff[EIV_BIT_POL_LSB +: NUM_EXT];
         end
      end
   end

   // Enable register, bit i gates source i
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         enables_ff <= EIV_RST_ENABLES;
      end else if (wr_fire && wr_sel == EIV_SEL_EN && w_strb_ff[0]) begin
         enables_ff <= w_data_ff[NUM_EXT-1:0];
      end
   end

   // Flags: write 1 to clear; a same-cycle edge wins over the clear
   assign flag_clear = (wr_fire && wr_sel == EIV_SEL_FLAGS && w_strb_ff[0])
                     ? w_data_ff[NUM_EXT-1:0] : '0;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         flags_ff <= EIV_RST_FLAGS;
      end else begin
         flags_ff <= (flags_ff & ~flag_clear) | edge_pulse;
      end
   end

   assign o_alt_vector_table_enable = alt_table_ff;
   assign o_ext_irq_flags           = flags_ff;
   assign o_ext_irq_req             = flags_ff & enables_ff;

   // ****************************************
   // AXI4-Lite read path
   // ****************************************
   assign o_arready = !rvalid_ff;
   assign rd_sel    = decode(i_araddr);
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;

   // Data captured at the address handshake and held until taken
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= EIV_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= EIV_RESP_OKAY;
         unique case (rd_sel)
            EIV_SEL_CTRL: begin
               rdata_ff <= widen(polarity_ff);
               rdata_ff[EIV_BIT_ALT_TABLE] <= alt_table_ff;
               rdata_ff[EIV_BIT_DIS_STAT] <= i_irq_disable_instr_active;
            end
            EIV_SEL_FLAGS: rdata_ff <= widen(flags_ff);
            EIV_SEL_EN:    rdata_ff <= widen(enables_ff);
            EIV_SEL_NONE: begin
               rdata_ff <= '0;
               rresp_ff <= EIV_RESP_DECERR;
            end
         endcase
      end else if (i_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_edge_sets_flag: assert property (edge_pulse[0] |=> o_ext_irq_flags[0])
      else $error("edge on source 0 did not set flag bit 0");
   a_flag_sticky: assert property (flags_ff[1] && !flag_clear[1] |=> flags_ff[1])
      else $error("flag dropped without a software clear");
   a_req_from_edge: assert property (edge_pulse[0] && enables_ff[0] && !flag_clear[0]
      |=> o_ext_irq_req[0])
      else $error("enabled source 0 edge gave no request");
   a_alt_table_write: assert property (wr_fire && wr_sel == EIV_SEL_CTRL
      && w_strb_ff[EIV_BYTE_ALT]
      |=> o_alt_vector_table_enable == $past(w_data_ff[EIV_BIT_ALT_TABLE]))
      else $error("alternate table bit did not follow the write");
   a_status_readback: assert property (i_arvalid && o_arready && rd_sel == EIV_SEL_CTRL
      |=> o_rdata[EIV_BIT_DIS_STAT] == $past(i_irq_disable_instr_active))
      else $error("status bit 14 does not show the instruction state");
   a_pol_reset_zero: assert property ($fell(i_rst) |-> polarity_ff == '0)
      else $error("polarity bits not clear after reset");
   a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data changed before it was taken");
   a_unmapped_err: assert property (i_arvalid && o_arready && rd_sel == EIV_SEL_NONE
      |=> o_rresp == EIV_RESP_DECERR)
      else $error("unmapped read did not answer with an error");

   c_flag_set: cover property (edge_pulse[0] ##1 flags_ff[0]);
   c_clear_vs_set: cover property (edge_pulse[2] && flag_clear[2]);
   c_falling_mode: cover property (polarity_ff[3] && edge_pulse[3]);
   c_write_done: cover property (wr_fire ##1 o_bvalid && i_bready);
endmodule // eiv_ctrl

// *** dv/eiv_pin_model.sv ***
// Model of the external interrupt request pins driving the block
`timescale 1ns/1ps
module eiv_pin_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic [4:0] i_level,
   input  wire logic       i_slow,
   output logic      [4:0] o_pins
);
   logic [4:0] stage_ff;
   logic [4:0] pins_ff;

   // Pins hold their level between changes; slow mode lags one cycle more
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stage_ff <= 5'h00;
         pins_ff  <= 5'h00;
      end else begin
         stage_ff <= i_level;
         pins_ff  <= i_slow ? stage_ff : i_level;
      end
   end
   assign o_pins = pins_ff;
endmodule // eiv_pin_model

// *** dv/tb.sv ***
// Self-checking bench for the vector and edge control block
`timescale 1ns/1ps
module tb;
   import eiv_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rd, rv, seed = 32'h249e;
   logic [4:0]  lvl = 5'h00, pins, flags, req, pol, old, expf;
   logic        slow = 1'b0, dis_act = 1'b0, alt, awready, wready, bvalid, arready, rvalid;
   logic        rd_late = 1'b0;
   logic [1:0]  rsp, bresp, rresp;
   logic [31:0] rdata;
   int          num_errors = 0, tests_run = 0, cycles = 0;

   eiv_pin_model u_eiv_pin_model (.i_clock(i_clock), .i_rst(i_rst), .i_level(lvl),
      .i_slow(slow), .o_pins(pins));
   eiv_ctrl u_eiv_ctrl (.i_clock(i_clock), .i_rst(i_rst), .i_awvalid(awvalid),
      .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
      .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .i_ext_irq_pins(pins), .i_irq_disable_instr_active(dis_act),
      .o_alt_vector_table_enable(alt), .o_ext_irq_flags(flags), .o_ext_irq_req(req));

   // Free-running clock
   always #10 i_clock = ~i_clock;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Flag set where the pin moved in the chosen direction
   function automatic logic [4:0] exp_flags(input logic [4:0] o, n, p);
      return (o ^ n) & (n ^ p);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each released once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      // One edge between transfers so no signal is driven twice in a step
      @(posedge i_clock);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge i_clock);
         if (awready === 1'b1) aw_done = 1'b1;
         if (wready === 1'b1) w_done = 1'b1;
         if (aw_done) awvalid <= 1'b0;
         if (w_done) wvalid <= 1'b0;
      end
      do @(posedge i_clock); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   // Read: rready held high until the data is sampled; rd_late holds it off a cycle
   task automatic axi_rd(input logic [3:0] a);
      @(posedge i_clock);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= !rd_late;
      do @(posedge i_clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      if (rd_late) begin
         @(posedge i_clock);
         rready <= 1'b1;
      end
      do @(posedge i_clock); while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      tick(3);
      i_rst <= 1'b0;
      tick(1);
      axi_rd(EIV_OFF_CTRL_TWO);
      chk_val(rd, 32'h0);
      axi_rd(EIV_OFF_FLAGS);
      chk_val(rd, 32'h0);
      // Table select both ways; writes to the status bit are dropped
      for (int v = 1; v >= 0; v--) begin
         axi_wr(EIV_OFF_CTRL_TWO, {16'h0, v[0], 15'h4000}, 4'h3);
         chk_val({31'h0, alt}, v);
         axi_rd(EIV_OFF_CTRL_TWO);
         chk_val(rd, {16'h0, v[0], 15'h0});
      end
      dis_act <= 1'b1;
      axi_rd(EIV_OFF_CTRL_TWO);
      chk_val(rd, 32'h4000);
      dis_act <= 1'b0;
      // Low strobe only reaches the polarity field
      axi_wr(EIV_OFF_CTRL_TWO, 32'h801f, 4'h1);
      axi_rd(EIV_OFF_CTRL_TWO);
      chk_val(rd, 32'h1f);
      // Source 0 alone, rising edge, not seen too early
      axi_wr(EIV_OFF_CTRL_TWO, 32'h0, 4'h1);
      lvl <= 5'h01;
      tick(2);
      chk_val({27'h0, flags}, 32'h0);
      tick(6);
      axi_rd(EIV_OFF_FLAGS);
      chk_val(rd, 32'h1);
      // Random polarities and pin moves
      for (int k = 0; k < 16; k++) begin
         rv = rnd();
         pol = rv[4:0];
         axi_wr(EIV_OFF_CTRL_TWO, {27'h0, pol}, 4'h1);
         chk_resp(rsp, EIV_RESP_OKAY);
         old = rv[9:5];
         lvl <= old;
         slow <= rv[10];
         tick(8);
         axi_wr(EIV_OFF_FLAGS, 32'h1f, 4'h1);
         rv = rnd();
         lvl <= rv[4:0];
         tick(8);
         expf = exp_flags(old, rv[4:0], pol);
         chk_val({27'h0, flags}, {27'h0, expf});
         axi_wr(EIV_OFF_ENABLES, {27'h0, rv[9:5]}, 4'h1);
         chk_val({27'h0, req}, {27'h0, expf & rv[9:5]});
         tick(5);
         // Random late rready: read data must stand while it waits
         rd_late = rv[11];
         axi_rd(EIV_OFF_FLAGS);
         rd_late = 1'b0;
         chk_val(rd, {27'h0, expf});
         axi_wr(EIV_OFF_FLAGS, 32'h1f, 4'h1);
         chk_val({27'h0, flags}, 32'h0);
      end
      // Mid-run reset clears the written fields again
      axi_wr(EIV_OFF_CTRL_TWO, 32'h801f, 4'h3);
      chk_val({31'h0, alt}, 32'h1);
      i_rst <= 1'b1;
      tick(2);
      i_rst <= 1'b0;
      tick(1);
      chk_val({31'h0, alt}, 32'h0);
      axi_rd(EIV_OFF_CTRL_TWO);
      chk_val(rd, 32'h0);
      // Unmapped word answers with a decode error
      axi_rd(4'hc);
      chk_resp(rsp, EIV_RESP_DECERR);
      chk_val(rd, 32'h0);
      axi_wr(4'hc, 32'hffff, 4'hf);
      chk_resp(rsp, EIV_RESP_DECERR);
      end_of_test();
   end
endmodule // tb
